// >>> logic/bphc_halt_ctrl.v
`include "bphc_map.vh"
module bphc_halt_ctrl (
  clk_sys,
  resetn,
  regAddr,
  regWrData,
  regWrite,
  regRead,
  regRdData,
  takeValid,
  takeAddr,
  instrDone,
  nextSeg,
  nextPtr,
  fatalError,
  emuRun,
  startPulse,
  startSeg,
  startPtr,
  haltPulse
);
  input  wire        clk_sys;
  input  wire        resetn;
  input  wire [3:0]  regAddr;
  input  wire [31:0] regWrData;
  input  wire        regWrite;
  input  wire        regRead;
  output reg  [31:0] regRdData;
  input  wire        takeValid;
  input  wire [19:0] takeAddr;
  input  wire        instrDone;
  input  wire [15:0] nextSeg;
  input  wire [15:0] nextPtr;
  input  wire        fatalError;
  output reg         emuRun;
  output reg         startPulse;
  output reg  [15:0] startSeg;
  output reg  [15:0] startPtr;
  output reg         haltPulse;

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg  [15:0] cseg_q;
  reg  [15:0] iptr_q;
  reg  [15:0] base_q;
  reg  [15:0] disp_q;
  reg  [19:0] mval_q;
  reg  [19:0] mcare_q;
  reg  [1:0]  kind_q;
  reg  [19:0] m0Val_q;  // 20-bit execution match address
  reg  [19:0] m0Care_q; // per-bit care, a zero bit is don't-care
  reg  [19:0] m1Val_q;
  reg  [19:0] m1Care_q;
  reg  [1:0]  goCtl_q;
  reg         abortPend_q;
  reg         andErr_q;
  reg         hitFlag_q;
  reg         fatalFlag_q;
  reg         abortFlag_q;
  wire [19:0] formVal;
  wire [19:0] formCare;
  wire        hit0;
  wire        hit1;
  wire        en0;
  wire        en1;
  wire        cmdWr;
  wire [1:0]  nCond;

  assign cmdWr = regWrite & (regAddr == `BPHC_REG_CMD);
  assign nCond = regWrData[`BPHC_CMD_NCOND_LSB+1:`BPHC_CMD_NCOND_LSB];
  assign en0   = (goCtl_q != `BPHC_GO_FOREVER);
  assign en1   = (goCtl_q == `BPHC_GO_OR);

  bphc_addr_form uForm (
    .entryKind  (kind_q),
    .baseWord   (base_q),
    .dispWord   (disp_q),
    .maskedVal  (mval_q),
    .maskedCare (mcare_q),
    .matchVal   (formVal),
    .matchCare  (formCare)
  );

  bphc_exec_match uMatch0 (
    .takeValid (takeValid & emuRun),
    .takeAddr  (takeAddr),
    .regVal    (m0Val_q),
    .regCare   (m0Care_q),
    .regEnable (en0),
    .hit       (hit0)
  );

  bphc_exec_match uMatch1 (
    .takeValid (takeValid & emuRun),
    .takeAddr  (takeAddr),
    .regVal    (m1Val_q),
    .regCare   (m1Care_q),
    .regEnable (en1),
    .hit       (hit1)
  );

  // ----------------------------------------
  // entry staging registers
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!resetn) begin
      base_q  <= `BPHC_WORD_ZERO;
      disp_q  <= `BPHC_WORD_ZERO;
      mval_q  <= `BPHC_ADDR_ZERO;
      mcare_q <= `BPHC_CARE_NONE;
      kind_q  <= `BPHC_ENTRY_PLAIN;
    end else if (regWrite) begin
      case (regAddr)
        `BPHC_REG_ADDRBASE: base_q <= regWrData[15:0];
        `BPHC_REG_ADDRDISP: disp_q <= regWrData[15:0];
        `BPHC_REG_CARE_LO: begin
          mval_q  <= regWrData[19:0];
        end
        `BPHC_REG_CARE_HI: mcare_q <= regWrData[19:0];
        `BPHC_REG_ENTRY:   kind_q  <= regWrData[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // go control, match registers and run state
  // ----------------------------------------
  always @(posedge clk_sys) begin
    startPulse <= 1'b0;
    haltPulse  <= 1'b0;
    if (!resetn) begin
      goCtl_q     <= `BPHC_GO_FOREVER;
      m0Val_q     <= `BPHC_ADDR_ZERO;
      m0Care_q    <= `BPHC_CARE_NONE;
      m1Val_q     <= `BPHC_ADDR_ZERO;
      m1Care_q    <= `BPHC_CARE_NONE;
      cseg_q      <= `BPHC_WORD_ZERO;
      iptr_q      <= `BPHC_WORD_ZERO;
      emuRun      <= 1'b0;
      startSeg    <= `BPHC_WORD_ZERO;
      startPtr    <= `BPHC_WORD_ZERO;
      abortPend_q <= 1'b0;
      andErr_q    <= 1'b0;
      hitFlag_q   <= 1'b0;
      fatalFlag_q <= 1'b0;
      abortFlag_q <= 1'b0;
    end else begin
      // software may set segment and pointer while halted
      if (regWrite && !emuRun && regAddr == `BPHC_REG_CSEG)
        cseg_q <= regWrData[15:0];
      if (regWrite && !emuRun && regAddr == `BPHC_REG_IPTR)
        iptr_q <= regWrData[15:0];
      // store formed entry into a register without starting
      if (cmdWr && !emuRun && regWrData[`BPHC_CMD_STORE0]) begin
        m0Val_q  <= formVal;
        m0Care_q <= formCare;
      end
      if (cmdWr && !emuRun && regWrData[`BPHC_CMD_STORE1]) begin
        m1Val_q  <= formVal;
        m1Care_q <= formCare;
      end
      // code loaded: entry point taken from the formed base and offset
      if (cmdWr && !emuRun && regWrData[`BPHC_CMD_LOADED]) begin
        cseg_q <= base_q;
        iptr_q <= disp_q;
      end
      if (cmdWr && !emuRun && regWrData[`BPHC_CMD_START]) begin
        if (nCond == 2'h2 && regWrData[`BPHC_CMD_COMBINE] == `BPHC_COMB_AND) begin
          andErr_q <= 1'b1; // request dropped whole
        end else begin
          andErr_q    <= 1'b0;
          hitFlag_q   <= 1'b0;
          fatalFlag_q <= 1'b0;
          abortFlag_q <= 1'b0;
          emuRun      <= 1'b1;
          startPulse  <= 1'b1;
          if (regWrData[`BPHC_CMD_FROM]) begin
            startSeg <= base_q;
            startPtr <= disp_q;
          end else begin
            startSeg <= cseg_q;
            startPtr <= iptr_q;
          end
          if (regWrData[`BPHC_CMD_FOREVER]) begin
            goCtl_q <= `BPHC_GO_FOREVER;
          end else if (nCond == 2'h1) begin
            goCtl_q <= `BPHC_GO_ONE;
            m0Val_q  <= formVal;
            m0Care_q <= formCare;
          end else if (nCond == 2'h2) begin
            // second register was staged by an earlier store
            goCtl_q <= `BPHC_GO_OR;
            m0Val_q  <= formVal;
            m0Care_q <= formCare;
          end
        end
      end
      // abort waits for the instruction in progress to end
      if (cmdWr && emuRun && regWrData[`BPHC_CMD_ABORT])
        abortPend_q <= 1'b1;
      if (emuRun) begin
        if (fatalError) begin
          emuRun      <= 1'b0;
          haltPulse   <= 1'b1;
          fatalFlag_q <= 1'b1;
          abortPend_q <= 1'b0;
        end else if (hit0 | hit1) begin
          emuRun      <= 1'b0;
          haltPulse   <= 1'b1;
          hitFlag_q   <= 1'b1;
          // a pending abort must not survive into the next run
          abortPend_q <= 1'b0;
        end else if (abortPend_q && instrDone) begin
          emuRun      <= 1'b0;
          haltPulse   <= 1'b1;
          abortFlag_q <= 1'b1;
          abortPend_q <= 1'b0;
        end
        // keep the next-instruction location current while running
        if (instrDone) begin
          cseg_q <= nextSeg;
          iptr_q <= nextPtr;
        end
      end
    end
  end

  // ----------------------------------------
  // read port: data stands one cycle after the strobe
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!resetn) begin
      regRdData <= 32'h00000000;
    end else if (regRead) begin
      case (regAddr)
        `BPHC_REG_CSEG:     regRdData <= {16'h0000, cseg_q};
        `BPHC_REG_IPTR:     regRdData <= {16'h0000, iptr_q};
        `BPHC_REG_ADDRBASE: regRdData <= {16'h0000, base_q};
        `BPHC_REG_ADDRDISP: regRdData <= {16'h0000, disp_q};
        `BPHC_REG_CARE_LO:  regRdData <= {12'h000, mval_q};
        `BPHC_REG_CARE_HI:  regRdData <= {12'h000, mcare_q};
        `BPHC_REG_ENTRY:    regRdData <= {30'h0, kind_q};
        `BPHC_REG_STATUS:   regRdData <= {24'h000000, abortPend_q, abortFlag_q, fatalFlag_q, hitFlag_q,
                                          andErr_q, emuRun, goCtl_q};
        `BPHC_REG_M0_VAL:   regRdData <= {12'h000, m0Val_q};
        `BPHC_REG_M0_CARE:  regRdData <= {12'h000, m0Care_q};
        `BPHC_REG_M1_VAL:   regRdData <= {12'h000, m1Val_q};
        `BPHC_REG_M1_CARE:  regRdData <= {12'h000, m1Care_q};
        default:            regRdData <= 32'h00000000;
      endcase
    end else begin
      regRdData <= 32'h00000000;
    end
  end
endmodule // bphc_halt_ctrl

// >>> logic/bphc_map.vh
`ifndef BPHC_MAP_VH
`define BPHC_MAP_VH
// Functional notes
// - after load, go control is forever: no halt factor enabled; reset and a start with forever set forever, a code load leaves go control unchanged.
// - at init both match registers hold all don't-care and are disabled.
// - after code load, segment and pointer take the first instruction location.
// - start begins at the current segment and pointer.
// - start with a location begins there instead.
// - with no halt factor, run until abort or fatal error.
// - abort finishes current instruction, stops pointing at the next one.
// - start with forever disables every halt factor.
// - start with conditions loads and enables the match registers; the start loads only the first, the second keeps what a store put there.
// - match condition is 20-bit address, per-bit 0/1/don't-care, plus executed.
// - match is evaluated only on queue take, not on prefetch.
// - match when executed byte address equals all cared bits.
// - plain address without base is reduced modulo 65536.
// - masked entry loads 0/1/don't-care; don't-care bits ignored.
// - single condition loads first register only; second untouched.
// - OR puts one condition in each register; halt on either match.
// - AND of two execution conditions is rejected and not carried out.

// ----------------------------------------
// register offsets
// ----------------------------------------
`define BPHC_ADDR_W        4
`define BPHC_REG_CMD       4'h0
`define BPHC_REG_CSEG      4'h1
`define BPHC_REG_IPTR      4'h2
`define BPHC_REG_ADDRBASE  4'h3
`define BPHC_REG_ADDRDISP  4'h4
`define BPHC_REG_CARE_LO   4'h5
`define BPHC_REG_CARE_HI   4'h6
`define BPHC_REG_ENTRY     4'h7
`define BPHC_REG_STATUS    4'h8
`define BPHC_REG_M0_VAL    4'h9
`define BPHC_REG_M0_CARE   4'ha
`define BPHC_REG_M1_VAL    4'hb
`define BPHC_REG_M1_CARE   4'hc

// ----------------------------------------
// command register fields
// ----------------------------------------
`define BPHC_CMD_START     0
`define BPHC_CMD_FROM      1
`define BPHC_CMD_FOREVER   2
`define BPHC_CMD_ABORT     3
`define BPHC_CMD_LOADED    4
`define BPHC_CMD_COMBINE   5
`define BPHC_CMD_STORE0    6
`define BPHC_CMD_STORE1    7
`define BPHC_CMD_NCOND_LSB 8

// ----------------------------------------
// entry kinds and combine modes
// ----------------------------------------
`define BPHC_ENTRY_PLAIN   2'h0
`define BPHC_ENTRY_BASED   2'h1
`define BPHC_ENTRY_MASKED  2'h2
`define BPHC_COMB_OR       1'b0
`define BPHC_COMB_AND      1'b1

// ----------------------------------------
// go control settings and reset values
// ----------------------------------------
`define BPHC_GO_FOREVER    2'h0
`define BPHC_GO_ONE        2'h1
`define BPHC_GO_OR         2'h2
`define BPHC_CARE_NONE     20'h00000
`define BPHC_ADDR_ZERO     20'h00000
`define BPHC_WORD_ZERO     16'h0000

`endif

// >>> logic/bphc_addr_form.v
`include "bphc_map.vh"
// forms a 20-bit match value and care mask from one console entry
module bphc_addr_form (
  input  wire [1:0]  entryKind,
  input  wire [15:0] baseWord,
  input  wire [15:0] dispWord,
  input  wire [19:0] maskedVal,
  input  wire [19:0] maskedCare,
  output reg  [19:0] matchVal,
  output reg  [19:0] matchCare
);
  // ----------------------------------------
  // entry decode
  // ----------------------------------------
  always @* begin
    case (entryKind)
      `BPHC_ENTRY_PLAIN: begin
        // a 16-bit word already is the value modulo 65536
        matchVal  = {4'h0, dispWord};
        matchCare = 20'hfffff;
      end
      `BPHC_ENTRY_BASED: begin
        matchVal  = {baseWord, 4'h0} + {4'h0, dispWord};
        matchCare = 20'hfffff;
      end
      `BPHC_ENTRY_MASKED: begin
        matchVal  = maskedVal & maskedCare;
        matchCare = maskedCare;
      end
      default: begin
        matchVal  = `BPHC_ADDR_ZERO;
        matchCare = `BPHC_CARE_NONE;
      end
    endcase
  end
endmodule // bphc_addr_form

// >>> logic/bphc_exec_match.v
`include "bphc_map.vh"
// compares one executed byte address against one match register
module bphc_exec_match (
  input  wire        takeValid,
  input  wire [19:0] takeAddr,
  input  wire [19:0] regVal,
  input  wire [19:0] regCare,
  input  wire        regEnable,
  output wire        hit
);
  // prefetches never reach here: only queue takes qualify
  assign hit = regEnable & takeValid & (((takeAddr ^ regVal) & regCare) == 20'h00000);
endmodule // bphc_exec_match

// >>> test/bphc_checker.sv
`include "bphc_map.vh"
// watches the control block at its own ports only
module bphc_checker (
  input wire        clk_sys,
  input wire        resetn,
  input wire [3:0]  regAddr,
  input wire [31:0] regWrData,
  input wire        regWrite,
  input wire        regRead,
  input wire [31:0] regRdData,
  input wire        fatalError,
  input wire        emuRun,
  input wire        startPulse,
  input wire        haltPulse
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // command decode
  // ----------------------------------------
  wire startCmd = regWrite && regAddr == `BPHC_REG_CMD && regWrData[`BPHC_CMD_START];
  wire andCmd   = regWrData[`BPHC_CMD_COMBINE] && regWrData[9:8] == 2'h2; // two conditions joined by and
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_read_quiet: assert property (!$past(regRead) |-> regRdData == 32'h0)
    else $error("read data outside its cycle");
  a_start_taken: assert property (startCmd && !andCmd && !emuRun |=> startPulse && emuRun)
    else $error("start request not carried out");
  a_and_refused: assert property (startCmd && andCmd && !emuRun |=> !startPulse && !emuRun)
    else $error("and of two conditions was started");
  a_run_rise: assert property ($rose(emuRun) |-> startPulse)
    else $error("run began without start");
  a_start_single: assert property (startPulse |=> !startPulse)
    else $error("start pulse too long");
  a_halt_falls: assert property (haltPulse |-> !emuRun && $past(emuRun))
    else $error("halt pulse without a stop");
  a_halt_single: assert property (haltPulse |=> !haltPulse)
    else $error("halt pulse too long");
  a_fatal_halt: assert property (emuRun && fatalError |=> haltPulse && !emuRun)
    else $error("fatal error did not halt");
endmodule // bphc_checker

bind bphc_halt_ctrl bphc_checker i_bphc_checker (.clk_sys, .resetn, .regAddr, .regWrData, .regWrite,
  .regRead, .regRdData, .fatalError, .emuRun, .startPulse, .haltPulse);

// >>> test/bphc_proc_model.sv
// emulation processor: one-byte instructions, one taken and retired per cycle while running
module bphc_proc_model (
  input  wire         clk_sys,
  input  wire         emuRun,
  input  wire         startPulse,
  input  wire  [15:0] startSeg,
  input  wire  [15:0] startPtr,
  output logic        takeValid,
  output logic [19:0] takeAddr,
  output logic        instrDone,
  output logic [15:0] nextSeg,
  output logic [15:0] nextPtr,
  output logic [19:0] lastTake,
  output logic [15:0] lastNext
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] seg, ptr, s, p;
  initial begin
    {takeValid, instrDone, takeAddr, nextSeg, nextPtr, lastTake, lastNext} = '0;
    {seg, ptr} = '0;
  end
  // the byte address is base shifted four plus offset; idle lines toggle so stale values never pass
  always @(posedge clk_sys) begin
    if (emuRun && takeValid) lastTake <= takeAddr;
    if (emuRun && instrDone) lastNext <= nextPtr;
    s = startPulse ? startSeg : seg;
    p = startPulse ? startPtr : ptr;
    takeValid <= emuRun;
    instrDone <= emuRun;
    if (emuRun) begin
      takeAddr <= {s, 4'h0} + p;
      nextSeg <= s;
      nextPtr <= p + 16'h1;
      seg <= s;
      ptr <= p + 16'h1;
    end else begin
      takeAddr <= ~takeAddr;
      nextSeg <= ~nextSeg;
      nextPtr <= ~nextPtr;
    end
  end
endmodule // bphc_proc_model

// >>> test/tb.sv
`include "bphc_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 0, resetn = 0, regWrite = 0, regRead = 0, fatalError = 0, rdPend = 0;
  logic [3:0]  regAddr = 0;
  logic [31:0] regWrData = 0;
  wire  [31:0] regRdData;
  wire         takeValid, instrDone, emuRun, startPulse, haltPulse;
  wire  [19:0] takeAddr, lastTake;
  wire  [15:0] nextSeg, nextPtr, startSeg, startPtr, lastNext;
  logic [63:0] rdQ[$], n;
  logic [31:0] stQ[$];
  logic [19:0] hitQ[$];
  int          mismatches = 0, checks = 0, cyc = 0, seed = 21319;
  always #2 clk_sys = ~clk_sys;
  bphc_halt_ctrl i_bphc_halt_ctrl (.clk_sys, .resetn, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
    .takeValid, .takeAddr, .instrDone, .nextSeg, .nextPtr, .fatalError, .emuRun, .startPulse, .startSeg,
    .startPtr, .haltPulse);
  bphc_proc_model i_bphc_proc_model (.clk_sys, .emuRun, .startPulse, .startSeg, .startPtr, .takeValid,
    .takeAddr, .instrDone, .nextSeg, .nextPtr, .lastTake, .lastNext);
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // a gap cycle after each strobe keeps one assignment per signal per step
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    regAddr <= a; regWrData <= d; regWrite <= 1; @(posedge clk_sys);
    regWrite <= 0; @(posedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    rdQ.push_back({m, e}); regAddr <= a; regRead <= 1; @(posedge clk_sys);
    regRead <= 0; @(posedge clk_sys);
  endtask
  // a run that never halts within the limit counts as a mismatch
  task automatic waitHalt;
    for (int i = 0; i < 200 && emuRun; i++) @(posedge clk_sys);
    cmp({31'h0, emuRun}, 32'h0);
  endtask
  // ----------------------------------------
  // monitor: oldest note against each result
  // ----------------------------------------
  always @(posedge clk_sys) begin
    cyc++;
    if (rdPend) begin
      n = rdQ.pop_front();
      cmp(regRdData & n[63:32], n[31:0]);
    end
    rdPend <= regRead;
    if (startPulse) cmp({startSeg, startPtr}, stQ.size() ? stQ.pop_front() : 32'hx);
    if (haltPulse && hitQ.size() != 0) cmp(lastTake, hitQ.pop_front());
    if (cyc == 4000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    logic [15:0] s;
    logic [19:0] t, c;
    repeat (3) @(posedge clk_sys);
    resetn <= 1;
    @(posedge clk_sys);
    rd(`BPHC_REG_STATUS, 32'h0);
    rd(`BPHC_REG_M0_CARE, 32'h0);
    rd(`BPHC_REG_M1_CARE, 32'h0);
    $display("done: reset state");
    wr(`BPHC_REG_ADDRBASE, 32'h100); wr(`BPHC_REG_ADDRDISP, 32'h210); wr(`BPHC_REG_CMD, 32'h10);
    rd(`BPHC_REG_IPTR, 32'h210);
    stQ.push_back(32'h01000210); wr(`BPHC_REG_CMD, 32'h1);
    repeat (20) @(posedge clk_sys);
    rd(`BPHC_REG_STATUS, 32'h4, 32'h7);
    wr(`BPHC_REG_CMD, 32'h8); waitHalt;
    rd(`BPHC_REG_IPTR, {16'h0, lastNext});
    $display("done: start and abort");
    // plain, segment plus offset, masked; the halt byte is five past the start, or four past it for the masked entry when that address is odd
    for (int k = 0; k < 3; k++) begin
      s = 16'h0200 + ($random(seed) & 16'hff);
      t = 20'h01000 + s + 20'h5;
      c = (k == 2) ? 20'hffffe : 20'hfffff;
      wr(`BPHC_REG_CSEG, 32'h100); wr(`BPHC_REG_IPTR, s); wr(`BPHC_REG_ENTRY, k);
      wr(`BPHC_REG_ADDRBASE, k ? 32'h101 : t[15:0]);
      // the plain entry carries a bit above 16 that must be dropped
      wr(`BPHC_REG_ADDRDISP, k ? s - 16'hb : 32'h10000 | t[15:0]);
      wr(`BPHC_REG_CARE_LO, t & c); wr(`BPHC_REG_CARE_HI, c);
      stQ.push_back({16'h0100, s}); hitQ.push_back(t & c);
      wr(`BPHC_REG_CMD, 32'h101); waitHalt;
      rd(`BPHC_REG_STATUS, 32'h11, 32'h17);
      rd(`BPHC_REG_M0_VAL, t & c); rd(`BPHC_REG_M0_CARE, c);
      rd(`BPHC_REG_M1_CARE, 32'h0);
    end
    $display("done: single conditions");
    wr(`BPHC_REG_ENTRY, 32'h2); wr(`BPHC_REG_CARE_LO, t - 20'h2); wr(`BPHC_REG_CARE_HI, 32'hfffff);
    wr(`BPHC_REG_CMD, 32'hc0);
    rd(`BPHC_REG_M0_VAL, t - 20'h2);
    wr(`BPHC_REG_ENTRY, 32'h1); wr(`BPHC_REG_ADDRDISP, s + 16'h9);
    wr(`BPHC_REG_CSEG, 32'h100); wr(`BPHC_REG_IPTR, s);
    stQ.push_back({16'h0100, s}); hitQ.push_back(t - 20'h2);
    wr(`BPHC_REG_CMD, 32'h201); waitHalt;
    rd(`BPHC_REG_STATUS, 32'h12, 32'h17);
    wr(`BPHC_REG_CMD, 32'h221); repeat (3) @(posedge clk_sys);
    rd(`BPHC_REG_STATUS, 32'ha, 32'hf);
    $display("done: or and and");
    // the start byte equals the first register's address, so only a disabled match keeps it running
    stQ.push_back({16'h0101, s + 16'h9}); wr(`BPHC_REG_CMD, 32'h7);
    repeat (10) @(posedge clk_sys);
    rd(`BPHC_REG_STATUS, 32'h4, 32'h7);
    fatalError <= 1; @(posedge clk_sys); fatalError <= 0; waitHalt;
    rd(`BPHC_REG_STATUS, 32'h20, 32'h24);
    $display("done: forever and fatal");
    repeat (4) @(posedge clk_sys);
    tally_and_finish();
  end
endmodule // tb
